// [dv/lsd_driver_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_chk (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        clear_bar_input_i,
    input wire logic        xfer_select_i,
    input wire logic        shift_clock_i,
    input wire logic        serial_in_i,
    input wire logic        osc_i,
    input wire logic [31:0] segment_output_o,
    input wire logic [2:0]  backplane_drive_o,
    input wire logic        drive_polarity_o,
    input wire logic        bias_half_o,
    input wire logic        sleep_o,
    input wire logic        blank_o,
    input wire logic        overrun_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_reset_quiet: assert property (
        $rose(resetn_i) |-> segment_output_o == 32'h0 && backplane_drive_o == 3'h0)
        else $error("outputs not idle after reset");
    a_sleep_zeros: assert property (
        sleep_o [*2] |-> segment_output_o == 32'h0 && backplane_drive_o == 3'h0 && !drive_polarity_o)
        else $error("outputs active in sleep");
    a_bp_onehot: assert property (
        !sleep_o && !$past(sleep_o) && $past(resetn_i)
        |-> $onehot(backplane_drive_o ^ {3{drive_polarity_o}}))
        else $error("backplane not one-hot");
    a_blank_dark: assert property (
        blank_o && $past(blank_o) && !sleep_o |-> segment_output_o == {32{drive_polarity_o}})
        else $error("dots lit while blank");
    a_clear_resets: assert property (
        !clear_bar_input_i [*6] |-> {sleep_o, blank_o, bias_half_o, overrun_o} == 4'h0)
        else $error("control bits survive clear");
    a_ctrl_hold: assert property (
        (!xfer_select_i && clear_bar_input_i) [*8] |-> $stable({sleep_o, blank_o, bias_half_o}))
        else $error("control bits moved without latch");
    a_seg_hold: assert property (
        (!xfer_select_i && clear_bar_input_i) [*8] ##0 $stable({backplane_drive_o, drive_polarity_o})
        |-> $stable(segment_output_o))
        else $error("segments moved without cause");
    a_pol_dwell: assert property (
        $rose(drive_polarity_o) |=> drive_polarity_o [*8])
        else $error("polarity toggled too soon");
    a_overrun_hold: assert property (
        clear_bar_input_i [*5] ##0 overrun_o |=> overrun_o)
        else $error("overrun dropped without clear");
    c_sleep: cover property (sleep_o [*2]);
    c_blank: cover property (blank_o && !sleep_o);
    c_half: cover property ($rose(bias_half_o));
endmodule // lsd_chk
bind lsd_driver lsd_chk u_chk (.*);
`default_nettype wire

// [dv/lsd_driver_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module lsd_driver_tb_top;
    logic        clk_i = 0;
    logic        resetn_i = 0;
    logic        clear_bar_input_i = 1;
    logic        osc_i = 0;
    wire logic   sel, sck, sdi;
    logic [31:0] seg;
    logic [2:0]  bp;
    logic        pol, bias, sleep, blank, ovr;
    logic [98:0] fr;
    int          errors = 0;
    int          samples_checked = 0;
    time         t;
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always #20 osc_i = ~osc_i;
    lsd_host u_host (.clk_i(clk_i), .sel_o(sel), .sck_o(sck), .sdi_o(sdi));
    lsd_driver u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .clear_bar_input_i(clear_bar_input_i),
        .xfer_select_i(sel), .shift_clock_i(sck), .serial_in_i(sdi), .osc_i(osc_i),
        .segment_output_o(seg), .backplane_drive_o(bp), .drive_polarity_o(pol),
        .bias_half_o(bias), .sleep_o(sleep), .blank_o(blank), .overrun_o(ovr));
    task automatic results;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Samples three consecutive slots, 1280 clocks each at this osc rate
    task automatic chk_disp(input logic [98:0] f);
        int c, n;
        logic [31:0] e;
        repeat (3) begin
            repeat (1280) @(negedge clk_i);
            c = ((bp ^ {3{pol}}) == 3'h1) ? 1 : ((bp ^ {3{pol}}) == 3'h2) ? 2 : 3;
            for (n = 1; n <= 32; n++) e[n-1] = (f[99 - (3 * n - c + 1)] & ~f[2]) ^ pol;
            `CHK("segments", e, seg)
        end
    endtask
    initial begin
        repeat (90000) @(posedge clk_i);
        errors++;
        results;
    end
    initial begin
        repeat (5) @(negedge clk_i);
        resetn_i = 1;
        `CHK("seg_rst", 32'h0, seg)
        fr = {96'h9C3A_5F01_E7B2_48D6_A1C0_3E5B, 3'b000};
        u_host.send(fr, 1'b0, 99);
        chk_disp(fr);
        `CHK("bias", 1'b0, bias)
        fr = {96'h36E1_B70C_4D2F_8A95_0FF3_C6A1, 3'b001};
        u_host.send(fr, 1'b1, 99);
        `CHK("bias", 1'b1, bias)
        chk_disp(fr);
        u_host.junk;
        u_host.send(fr, 1'b1, 0);
        chk_disp(fr);
        fr[2] = 1'b1;
        u_host.send(fr, 1'b0, 99);
        `CHK("blank", 1'b1, blank)
        chk_disp(fr);
        @(posedge pol);
        t = $time;
        @(negedge pol);
        `CHK("frame_ns", 64'd15360, $time - t)
        fr[2:0] = 3'b010;
        u_host.send(fr, 1'b0, 99);
        `CHK("sleep", 37'h10_0000_0000, {sleep, bp, seg, pol})
        // Twice the power-up reset hold; the synchronous clear needs a few clocks
        clear_bar_input_i = 0;
        repeat (10) @(negedge clk_i);
        clear_bar_input_i = 1;
        `CHK("ctrl_clr", 3'h0, {sleep, blank, bias})
        chk_disp(99'h0);
        `CHK("overrun", 1'b0, ovr)
        results;
    end
endmodule // lsd_driver_tb_top
`default_nettype wire

// [dv/lsd_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_host (
    input  wire logic clk_i,
    output var logic  sel_o,
    output var logic  sck_o,
    output var logic  sdi_o
);
    initial begin
        sel_o = 1'b0;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Half of the 48 ns link period
    task automatic half;
        repeat (6) @(negedge clk_i);
    endtask
    // Clock and data wiggle with select low
    task automatic junk;
        repeat (4) begin
            sdi_o = ~sdi_o;
            half;
            sck_o = ~sck_o;
            half;
        end
    endtask
    // Sends the low n bits of f, highest first
    task automatic send(input logic [98:0] f, input logic idle, input int n);
        int i;
        sck_o = idle;
        half;
        sel_o = 1'b1;
        half;
        for (i = n - 1; i >= 0; i--) begin
            sck_o = 1'b0;
            sdi_o = f[i];
            half;
            sck_o = 1'b1;
            half;
        end
        sck_o = idle;
        half;
        sel_o = 1'b0;
        sdi_o = ~sdi_o;
        repeat (3) half;
    endtask
endmodule // lsd_host
`default_nettype wire

// [src/lsd_consts.vh]
`ifndef LSD_CONSTS_VH
`define LSD_CONSTS_VH

// Panel geometry
`define LSD_NUM_SEGS      32
`define LSD_NUM_BPS       3
`define LSD_DISP_BITS     96

// Serial frame: 96 display bits, then blank, sleep, bias
`define LSD_FRAME_BITS    99
`define LSD_BIT_BLANK     2
`define LSD_BIT_SLEEP     1
`define LSD_BIT_BIAS      0

// Timebase: frame length and backplane slot in oscillator periods
`define LSD_FRAME_DIV     384
`define LSD_SLOT_LEN      128
`define LSD_SLOT_SHIFT    7

// Link FIFO
`define LSD_FIFO_DEPTH    4
`define LSD_FIFO_WIDTH    2

`endif

// [src/lsd_driver.v]
`timescale 1ns/100ps
`default_nettype none
`include "lsd_consts.vh"

module lsd_driver #(
    parameter NUM_SEGS = `LSD_NUM_SEGS,
    parameter NUM_BPS  = `LSD_NUM_BPS,
    parameter FBITS    = `LSD_FRAME_BITS,
    parameter FDEPTH   = `LSD_FIFO_DEPTH
) (
    // Clock and reset
    input  wire                clk_i,
    input  wire                resetn_i,
    // Pins from the host
    input  wire                clear_bar_input_i,
    input  wire                xfer_select_i,
    input  wire                shift_clock_i,
    input  wire                serial_in_i,
    // Timebase pin
    input  wire                osc_i,
    // Panel drive
    output reg  [NUM_SEGS-1:0] segment_output_o,
    output reg  [NUM_BPS-1:0]  backplane_drive_o,
    output reg                 drive_polarity_o,
    output reg                 bias_half_o,
    // Status
    output reg                 sleep_o,
    output reg                 blank_o,
    output reg                 overrun_o
);
    // Two-stage synchronisers: clear, select, clock, data, oscillator
    reg  [4:0]        sync1_q;
    reg  [4:0]        sync2_q;
    reg  [4:0]        prev_q;
    wire              clr_n;
    wire              sel;
    wire              sck;
    wire              sdi;
    wire              osc;

    reg  [FBITS-1:0]  shift_q;
    reg  [FBITS-1:0]  pat_q;
    reg  [8:0]        div_q;
    reg               pol_q;

    wire              shift_rise;
    wire              sel_fall;
    wire              osc_rise;
    wire              push_valid;
    wire [1:0]        push_data;
    wire              push_ready;
    wire              pop_valid;
    wire [1:0]        pop_data;
    wire [1:0]        slot;
    wire              pat_sleep;
    wire              pat_blank;
    wire [NUM_SEGS-1:0] seg_on;

    assign clr_n = sync2_q[4];
    assign sel   = sync2_q[3];
    assign sck   = sync2_q[2];
    assign sdi   = sync2_q[1];
    assign osc   = sync2_q[0];

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= 5'h10;
            sync2_q <= 5'h10;
            prev_q  <= 5'h10;
        end else begin
            sync1_q <= {clear_bar_input_i, xfer_select_i, shift_clock_i, serial_in_i, osc_i};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Only rising edges of the shift clock count, so either idle level works
    assign shift_rise = sck & ~prev_q[2] & sel & clr_n;
    assign sel_fall   = ~sel & prev_q[3] & clr_n;
    assign osc_rise   = osc & ~prev_q[0];

    // Latch marker travels behind the data bits so it never overtakes them
    assign push_valid = shift_rise | sel_fall;
    assign push_data  = {sel_fall, sdi};
    // Drained during clear as well: events queued before the clear are thrown
    // away by the clear branch below instead of landing after it

    lsd_fifo #(
        .WIDTH (`LSD_FIFO_WIDTH),
        .DEPTH (FDEPTH),
        .AW    (2)
    ) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (pop_valid),
        .out_ready_i (1'b1),
        .out_data_o  (pop_data)
    );

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_q   <= {FBITS{1'b0}};
            pat_q     <= {FBITS{1'b0}};
            overrun_o <= 1'b0;
        end else if (!clr_n) begin
            shift_q   <= {FBITS{1'b0}};
            pat_q     <= {FBITS{1'b0}};
            overrun_o <= 1'b0;
        end else begin
            if (pop_valid && pop_data[1]) begin
                pat_q <= shift_q;
            end else if (pop_valid) begin
                shift_q <= {shift_q[FBITS-2:0], pop_data[0]};
            end
            // Sticky until clear: a lost bit corrupts the whole pattern
            // At one push and one pop per clock it stays low; kept as a guard
            if (push_valid && !push_ready) begin
                overrun_o <= 1'b1;
            end
        end
    end

    assign pat_sleep = pat_q[`LSD_BIT_SLEEP];
    assign pat_blank = pat_q[`LSD_BIT_BLANK];

    // Timebase; cleared and held at zero in sleep and during clear
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 9'h000;
            pol_q <= 1'b0;
        end else if (!clr_n || pat_sleep) begin
            div_q <= 9'h000;
            pol_q <= 1'b0;
        end else if (osc_rise) begin
            if (div_q == `LSD_FRAME_DIV - 1) begin
                div_q <= 9'h000;
                pol_q <= ~pol_q;
            end else begin
                div_q <= div_q + 9'h001;
            end
        end
    end

    // Slot 0 is backplane 1, slot 2 is backplane 3
    assign slot = div_q[8:`LSD_SLOT_SHIFT];

    genvar n;
    generate
        for (n = 0; n < NUM_SEGS; n = n + 1) begin : g_seg
            assign seg_on[n] = pat_q[96 - 3*n + slot];
        end
    endgenerate

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            segment_output_o  <= {NUM_SEGS{1'b0}};
            backplane_drive_o <= {NUM_BPS{1'b0}};
            drive_polarity_o  <= 1'b0;
            bias_half_o       <= 1'b0;
            sleep_o           <= 1'b0;
            blank_o           <= 1'b0;
        end else begin
            bias_half_o <= pat_q[`LSD_BIT_BIAS];
            sleep_o     <= pat_sleep;
            blank_o     <= pat_blank;
            if (pat_sleep) begin
                segment_output_o  <= {NUM_SEGS{1'b0}};
                backplane_drive_o <= {NUM_BPS{1'b0}};
                drive_polarity_o  <= 1'b0;
            end else begin
                // Segment level is dot state relative to frame polarity
                segment_output_o  <= (pat_blank ? {NUM_SEGS{1'b0}} : seg_on)
                                     ^ {NUM_SEGS{pol_q}};
                backplane_drive_o <= (3'h1 << slot) ^ {NUM_BPS{pol_q}};
                drive_polarity_o  <= pol_q;
            end
        end
    end
endmodule // lsd_driver

`default_nettype wire

// [src/lsd_fifo.v]
`timescale 1ns/100ps
`default_nettype none

module lsd_fifo #(
    parameter WIDTH = 2,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             resetn_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    integer         i;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q        <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // lsd_fifo

`default_nettype wire
